// file: rtl/dac_port_host.sv
`timescale 1ns/1ns
`default_nettype none

module dac_port_host
    import dac_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_chan,
    input wire logic [DATA_W-1:0] req_data,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic cs_n,
    output logic rw,
    output logic chan_sel,
    output logic [DATA_W-1:0] db_out,
    output logic db_drive_n,
    input wire logic [DATA_W-1:0] db_in
);

    port_state_e state_ff;
    port_state_e nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic cs_n_ff;
    logic rw_ff;
    logic chan_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic drive_n_ff;
    logic rd_valid_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] db_sync;
    logic accept;
    logic strobe_done;
    logic nxt_cs_n;
    logic nxt_drive_n;

    // Read data from the pins crosses into the clock domain here.
    pin_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_in(db_in),
        .pin_out(db_sync)
    );

    // Handshake and decode terms.
    assign req_ready = (state_ff == ST_IDLE);
    assign accept = req_valid && req_ready;
    assign strobe_done = (state_ff == ST_STROBE) && (cnt_ff == CNT_RESET);
    assign nxt_cs_n = (nxt_state != ST_STROBE);
    assign nxt_drive_n = !((nxt_state != ST_IDLE) && !rw_ff) || accept;

    // One access: setup with select high, strobe low, hold with select high.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                nxt_state = ST_STROBE;
                // Strobe carries the wait state; reads add settle time.
                nxt_cnt = rw_ff ? RD_CNT_LOAD : WR_CNT_LOAD;
            end
            ST_STROBE: begin
                if (strobe_done) begin
                    nxt_state = ST_HOLD;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_HOLD: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State and strobe timing.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= CNT_RESET;
            cs_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            cs_n_ff <= nxt_cs_n;
        end
    end

    // Direction, channel and word are held from accept until the next one.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rw_ff <= RW_RESET;
            chan_ff <= CHAN_RESET;
            wdata_ff <= DATA_RESET;
        end else if (accept) begin
            rw_ff <= !req_write;
            chan_ff <= req_chan;
            wdata_ff <= req_data;
        end
    end

    // Bus is driven only for writes, from setup through hold.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            drive_n_ff <= 1'b1;
        end else if (accept) begin
            drive_n_ff <= !req_write;
        end else begin
            drive_n_ff <= nxt_drive_n;
        end
    end

    // Read word is sampled at the end of the last strobe cycle, on the same edge that raises select.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= DATA_RESET;
        end else begin
            rd_valid_ff <= strobe_done && rw_ff;
            if (strobe_done && rw_ff) begin
                rd_data_ff <= db_sync;
            end
        end
    end

    assign cs_n = cs_n_ff;
    assign rw = rw_ff;
    assign chan_sel = chan_ff;
    assign db_out = wdata_ff;
    assign db_drive_n = drive_n_ff;
    assign rd_valid = rd_valid_ff;
    assign rd_data = rd_data_ff;

    // Write strobe: data driven and held still while select and rw are low.
    property p_write_drive;
        @(posedge clock) disable iff (!rst_n)
        (!cs_n && !rw) |-> (!db_drive_n && $stable(db_out));
    endproperty
    a_write_drive: assert property (p_write_drive)
        else $error("bus not driven during write strobe");

    // Bus released for any read access.
    property p_read_release;
        @(posedge clock) disable iff (!rst_n)
        (rw && state_ff != ST_IDLE) |-> db_drive_n;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("bus driven during read access");

    // Each accepted request gives one high-then-low select pair.
    property p_one_pair;
        @(posedge clock) disable iff (!rst_n)
        accept |=> cs_n ##1 !cs_n;
    endproperty
    a_one_pair: assert property (p_one_pair)
        else $error("select pair missing after request");

    // Write strobe lasts pulse time plus one wait state.
    property p_wr_strobe_len;
        @(posedge clock) disable iff (!rst_n)
        ($fell(cs_n) && !rw) |-> !cs_n [*3] ##1 cs_n;
    endproperty
    a_wr_strobe_len: assert property (p_wr_strobe_len)
        else $error("write strobe length wrong");

    // Read strobe adds synchroniser settle time.
    property p_rd_strobe_len;
        @(posedge clock) disable iff (!rst_n)
        ($fell(cs_n) && rw) |-> !cs_n [*7] ##1 (cs_n && rd_valid);
    endproperty
    a_rd_strobe_len: assert property (p_rd_strobe_len)
        else $error("read strobe length or data pulse wrong");

    // Channel and direction stay still around the whole strobe.
    property p_chan_stable;
        @(posedge clock) disable iff (!rst_n)
        (!cs_n || $past(cs_n) == 1'b0) |-> ($stable(chan_sel) && $stable(rw));
    endproperty
    a_chan_stable: assert property (p_chan_stable)
        else $error("channel or direction moved during strobe");

    // Select only goes low after a setup cycle with select high.
    property p_setup_first;
        @(posedge clock) disable iff (!rst_n)
        $fell(cs_n) |-> ($past(state_ff) == ST_SETUP);
    endproperty
    a_setup_first: assert property (p_setup_first)
        else $error("select fell without setup cycle");

endmodule

`default_nettype wire

// file: common/dac_host_pkg.sv
`default_nettype none

package dac_host_pkg;

    localparam int DATA_W = 12;
    localparam int CNT_W = 4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CS_PULSE_NS = 17;
    // Least pulse time rounds up to whole cycles.
    localparam int CS_PULSE_CYC = (CS_PULSE_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int WAIT_STATES = 1;
    localparam int WR_STROBE_CYC = CS_PULSE_CYC + WAIT_STATES;
    localparam int SYNC_STAGES = 3;
    // Three stages plus the agreement register before read data is usable.
    localparam int RD_SETTLE_CYC = SYNC_STAGES + 1;
    localparam int RD_STROBE_CYC = WR_STROBE_CYC + RD_SETTLE_CYC;
    localparam logic [CNT_W-1:0] WR_CNT_LOAD = CNT_W'(WR_STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] RD_CNT_LOAD = CNT_W'(RD_STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
    localparam logic RW_RESET = 1'b1;
    localparam logic CHAN_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD = 4'b1000
    } port_state_e;

endpackage

`default_nettype wire

// file: rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync
    import dac_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [DATA_W-1:0] pin_in,
    output logic [DATA_W-1:0] pin_out
);

    // Each bit passes three flops; its value is taken once stages two and
    // three agree, so a bit caught mid-change is never used.
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic agree_ff;
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    agree_ff <= 1'b0;
                end else begin
                    s1_ff <= pin_in[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        agree_ff <= s3_ff;
                    end
                end
            end
            assign pin_out[gi] = agree_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// file: tb/dac_device_model.sv
`timescale 1ns/1ns
`default_nettype none

module dac_device_model
    import dac_host_pkg::*;
(
    input wire logic cs_n,
    input wire logic rw,
    input wire logic chan_sel,
    input wire logic [DATA_W-1:0] db_out,
    input wire logic db_drive_n,
    output logic [DATA_W-1:0] db_in,
    output logic [DATA_W-1:0] dac0,
    output logic [DATA_W-1:0] dac1
);
    logic [DATA_W-1:0] in_reg;

    // Power-up leaves both converter registers at zero scale.
    initial begin
        dac0 = 12'h000;
        dac1 = 12'h000;
        in_reg = 12'h000;
    end

    // A read strobe copies the chosen register into the input register.
    always @(negedge cs_n) if (rw) in_reg = chan_sel ? dac1 : dac0;

    // The input register follows the whole word while a write is open.
    always @(db_out, cs_n, rw) if (!cs_n && !rw) in_reg = db_out;

    // The closing select edge of a write loads the chosen register.
    always @(posedge cs_n) begin
        if (!rw && chan_sel) dac1 = in_reg;
        if (!rw && !chan_sel) dac0 = in_reg;
    end

    // Released bus shows the input register during a read strobe and its inverse at all other times.
    assign db_in = !db_drive_n ? db_out : (!cs_n && rw) ? in_reg : ~in_reg;

endmodule

`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import dac_host_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_chan = 1'b0;
    logic [DATA_W-1:0] req_data = 12'h000;
    logic req_ready, rd_valid, cs_n, rw, chan_sel, db_drive_n;
    logic [DATA_W-1:0] rd_data, db_out, db_in, dac0, dac1;
    logic [DATA_W-1:0] q;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    dac_port_host uut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_chan(req_chan),
        .req_data(req_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .cs_n(cs_n), .rw(rw), .chan_sel(chan_sel), .db_out(db_out),
        .db_drive_n(db_drive_n), .db_in(db_in));

    dac_device_model dev (.cs_n(cs_n), .rw(rw), .chan_sel(chan_sel),
        .db_out(db_out), .db_drive_n(db_drive_n), .db_in(db_in),
        .dac0(dac0), .dac1(dac1));

    // The clock toggles every half period.
    initial begin
        forever #(CLK_PERIOD_NS / 2) clock = ~clock;
    end

    // A hung handshake is cut short here.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [DATA_W-1:0] exp,
            input logic [DATA_W-1:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access; checks the strobe length and what stands on the pins.
    task automatic access(input logic wr, input logic ch,
            input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
        int n;
        int low;
        logic ok;
        n = 0;
        low = 0;
        ok = 1'b1;
        r = 'x;
        req_write = wr;
        req_chan = ch;
        req_data = d;
        req_valid = 1'b1;
        @(posedge clock);
        #1 req_valid = 1'b0;
        do begin
            @(posedge clock);
            #1 n++;
            if (!cs_n) low++;
            if (!cs_n && (rw !== !wr || chan_sel !== ch)) ok = 1'b0;
            if (!cs_n && wr && (db_drive_n !== 1'b0 || db_out !== d)) begin
                ok = 1'b0;
            end
            if (!cs_n && !wr && db_drive_n !== 1'b1) ok = 1'b0;
            if (rd_valid === 1'b1) r = rd_data;
        end while (req_ready !== 1'b1 && n < 30);
        check("strobe pins", 12'h001, {11'h000, ok});
        check("strobe length", DATA_W'(wr ? WR_STROBE_CYC : RD_STROBE_CYC),
            DATA_W'(low));
    endtask

    task automatic test_reset();
        check("idle select", 12'h001, {11'h000, cs_n});
        check("idle drive", 12'h001, {11'h000, db_drive_n});
        check("idle ready", 12'h001, {11'h000, req_ready});
        $display("test reset done");
    endtask

    task automatic test_powerup_read();
        access(1'b0, 1'b1, 12'h000, q);
        check("power-up readback", 12'h000, q);
        $display("test power-up readback done");
    endtask

    task automatic test_write_pair();
        access(1'b1, 1'b0, 12'ha5c, q);
        access(1'b1, 1'b1, 12'h3f0, q);
        check("converter 0", 12'ha5c, dac0);
        check("converter 1", 12'h3f0, dac1);
        // The released bus differs from both words, so an early sample shows.
        access(1'b0, 1'b0, 12'h000, q);
        check("pair readback 0", 12'ha5c, q);
        access(1'b0, 1'b1, 12'h000, q);
        check("pair readback 1", 12'h3f0, q);
        $display("test write pair done");
    endtask

    task automatic test_boundary_readback();
        access(1'b1, 1'b1, 12'hfff, q);
        access(1'b1, 1'b0, 12'h000, q);
        // Channel 0 is read first, while the released bus shows all ones.
        access(1'b0, 1'b0, 12'h000, q);
        check("readback 0", 12'h000, q);
        access(1'b0, 1'b1, 12'h000, q);
        check("readback 1", 12'hfff, q);
        check("converter 1 kept", 12'hfff, dac1);
        $display("test boundary readback done");
    endtask

    // Reset for 16 cycles, then run every scenario.
    initial begin
        repeat (16) @(posedge clock);
        #1 rst_n = 1'b1;
        @(posedge clock);
        #1 test_reset();
        test_powerup_read();
        test_write_pair();
        test_boundary_readback();
        end_sim();
    end

endmodule

`default_nettype wire
